/* File: hdl/audio_host_control_registers.sv */
// Host register bank of the audio controller: indirect mode control, processor mailbox, codec setup.
//
// How it works
// - button IRQ routed by two-bit select.
// - external ROM status reads active low.
// - indirect registers 9-11 read as zero.
// - register 12 holds button and enable status.
// - reading register 12 clears button flags.
// - register 13 holds test, bass, enhanced bits.
// - register 13 bit 1 picks DAC format.
// - register 13 bit 0 picks synth source.
// - register 14 holds pin value/direction pairs.
// - index at F94, indirect data at F95.
// - writing bit 0 sets processor soft reset.
// - system reset clears soft reset flag.
// - processor output byte readable at A.
// - input-full set by host, cleared by processor.
// - status at C low bits mirror A.
// - host writes commands at offset C.
// - output-full set by processor, cleared by reads.
// - reading output status clears processor IRQ.
// - codec IRQ select, codes above 100 reserved.
// - codec DMA select maps play/capture channels.
// - sense bit picks normal or auto interrupt.
// - version register: channel, IRQ, version code.
// - version bit 6 shows codec IRQ active.
`timescale 1ns/100ps
`default_nettype none
`include "audio_host_defs.svh"

module audio_host_control_registers (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [11:0] io_addr_i,
  input wire logic io_rd_i,
  input wire logic io_wr_i,
  input wire logic [7:0] io_wdata_i,
  output logic [7:0] io_rdata_o,
  input wire logic [11:0] legacy_audio_base_i,
  input wire logic [11:0] codec_mode_base_i,
  input wire logic proc_in_take_i,
  output logic [7:0] proc_in_data_o,
  input wire logic proc_out_write_i,
  input wire logic [7:0] proc_out_data_i,
  input wire logic dma_out_read_i,
  input wire logic proc_irq_req_i,
  input wire logic proc_reset_done_i,
  output logic proc_soft_reset_o,
  output logic proc_irq_o,
  input wire logic vol_up_i,
  input wire logic vol_down_i,
  input wire logic ext_rom_select_n_i,
  input wire logic cd_iface_enabled_i,
  input wire logic auto_config_enabled_i,
  input wire logic channel_reduced_i,
  input wire logic codec_irq_i,
  output logic [2:0] button_irq_lines_o,
  output logic [3:0] codec_irq_lines_o,
  output logic codec_irq_sense_o,
  output audio_host_pkg::dma_route_t codec_dma_route_o,
  output audio_host_pkg::synth_opts_t synth_options_o,
  input wire logic [2:0] general_pin_i,
  output logic [2:0] general_pin_value_o,
  output logic [2:0] general_pin_direction_o
);
  import audio_host_pkg::*;

  logic [7:0] index_reg;
  logic [1:0] button_irq_select_reg;
  logic ext_rom_select_n_reg;
  logic cd_iface_enabled_reg;
  logic auto_config_enabled_reg;
  logic channel_reduced_reg;
  logic codec_irq_active_reg;
  logic vol_up_pressed_reg;
  logic vol_down_pressed_reg;
  logic both_buttons_pressed_reg;
  logic button_irq_pending_reg;
  logic input_buffer_full_reg;
  logic output_buffer_full_reg;
  logic [7:0] out_data_reg;
  codec_cfg_t codec_cfg_reg;
  logic [7:0] rdata_next;
  // Legacy block occupies an aligned 16-byte window, the codec block an aligned 4-byte window.
  wire hit_legacy = (io_addr_i[11:4] == legacy_audio_base_i[11:4]);
  wire hit_codec = (io_addr_i[11:2] == codec_mode_base_i[11:2]);
  wire hit_index = (io_addr_i == `AH_MC_INDEX_ADDR);
  wire hit_data = (io_addr_i == `AH_MC_DATA_ADDR);
  wire wr_index = io_wr_i && hit_index;
  wire wr_data = io_wr_i && hit_data;
  wire rd_data = io_rd_i && hit_data;
  wire wr_soft_reset = io_wr_i && hit_legacy && (io_addr_i[3:0] == `AH_OFS_SOFT_RESET);
  wire wr_command = io_wr_i && hit_legacy && (io_addr_i[3:0] == `AH_OFS_COMMAND);
  wire rd_read_data = io_rd_i && hit_legacy && (io_addr_i[3:0] == `AH_OFS_READ_DATA);
  wire rd_out_status = io_rd_i && hit_legacy && (io_addr_i[3:0] == `AH_OFS_OUT_STATUS);
  wire wr_codec_cfg = io_wr_i && hit_codec;
  wire btn_event = vol_up_i || vol_down_i;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      index_reg <= `AH_INDEX_RESET;
    else if (wr_index)
      index_reg <= io_wdata_i;
  end
  // Straps and status levels are sampled every cycle rather than caught in reset.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ext_rom_select_n_reg <= 1'b1;
      cd_iface_enabled_reg <= 1'b0;
      auto_config_enabled_reg <= 1'b0;
      channel_reduced_reg <= 1'b0;
      codec_irq_active_reg <= 1'b0;
    end
    else
    begin
      ext_rom_select_n_reg <= ext_rom_select_n_i;
      cd_iface_enabled_reg <= cd_iface_enabled_i;
      auto_config_enabled_reg <= auto_config_enabled_i;
      channel_reduced_reg <= channel_reduced_i;
      codec_irq_active_reg <= codec_irq_i;
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      button_irq_select_reg <= `AH_BTN_IRQ_OFF;
    else if (wr_data && index_reg == `AH_IDX_BUTTON_ROUTE)
      button_irq_select_reg <= io_wdata_i[`AH_BTN_SEL_LSB +: 2];
  end
  // A press in the same cycle as the clearing read is kept: set wins over clear.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      vol_up_pressed_reg <= 1'b0;
      vol_down_pressed_reg <= 1'b0;
      both_buttons_pressed_reg <= 1'b0;
      button_irq_pending_reg <= 1'b0;
    end
    else
    begin
      if (rd_data && index_reg == `AH_IDX_BUTTON_STATUS)
      begin
        vol_up_pressed_reg <= 1'b0;
        vol_down_pressed_reg <= 1'b0;
        both_buttons_pressed_reg <= 1'b0;
        button_irq_pending_reg <= 1'b0;
      end
      if (vol_up_i)
        vol_up_pressed_reg <= 1'b1;
      if (vol_down_i)
        vol_down_pressed_reg <= 1'b1;
      if (vol_up_i && vol_down_i)
        both_buttons_pressed_reg <= 1'b1;
      if (btn_event)
        button_irq_pending_reg <= 1'b1;
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      button_irq_lines_o <= 3'h0;
    else
    begin
      button_irq_lines_o[0] <= button_irq_pending_reg && button_irq_select_reg == `AH_BTN_IRQ_5;
      button_irq_lines_o[1] <= button_irq_pending_reg && button_irq_select_reg == `AH_BTN_IRQ_10;
      button_irq_lines_o[2] <= button_irq_pending_reg && button_irq_select_reg == `AH_BTN_IRQ_11;
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      synth_options_o <= `AH_SYNTH_RESET;
    else if (wr_data && index_reg == `AH_IDX_SYNTH_OPTIONS)
      synth_options_o <= io_wdata_i[4:0];
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      general_pin_value_o <= 3'h0;
      general_pin_direction_o <= 3'h0;
    end
    else if (wr_data && index_reg == `AH_IDX_GENERAL_PIN)
    begin
      general_pin_value_o <= {io_wdata_i[5], io_wdata_i[3], io_wdata_i[1]};
      general_pin_direction_o <= {io_wdata_i[4], io_wdata_i[2], io_wdata_i[0]};
    end
  end
  // Only system reset or the processor's acknowledge ends a soft reset; a new write wins.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      proc_soft_reset_o <= 1'b0;
    else if (wr_soft_reset && io_wdata_i[`AH_SOFT_RESET_BIT])
      proc_soft_reset_o <= 1'b1;
    else if (proc_reset_done_i)
      proc_soft_reset_o <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      input_buffer_full_reg <= 1'b0;
      proc_in_data_o <= 8'h00;
    end
    else if (wr_command)
    begin
      input_buffer_full_reg <= 1'b1;
      proc_in_data_o <= io_wdata_i;
    end
    else if (proc_in_take_i)
      input_buffer_full_reg <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      output_buffer_full_reg <= 1'b0;
      out_data_reg <= 8'h00;
    end
    else if (proc_out_write_i)
    begin
      output_buffer_full_reg <= 1'b1;
      out_data_reg <= proc_out_data_i;
    end
    else if (rd_read_data || dma_out_read_i)
      output_buffer_full_reg <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      proc_irq_o <= 1'b0;
    else if (proc_irq_req_i)
      proc_irq_o <= 1'b1;
    else if (rd_out_status)
      proc_irq_o <= 1'b0;
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      codec_cfg_reg <= `AH_CFG_RESET;
    else if (wr_codec_cfg)
      codec_cfg_reg <= io_wdata_i[6:0];
  end
  // Reserved interrupt codes leave every line quiet.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      codec_irq_lines_o <= 4'h0;
    else
    begin
      codec_irq_lines_o <= 4'h0;
      unique case (codec_cfg_reg.codec_irq_select)
        CODEC_IRQ_7: codec_irq_lines_o[0] <= codec_irq_active_reg;
        CODEC_IRQ_9: codec_irq_lines_o[1] <= codec_irq_active_reg;
        CODEC_IRQ_10: codec_irq_lines_o[2] <= codec_irq_active_reg;
        CODEC_IRQ_11: codec_irq_lines_o[3] <= codec_irq_active_reg;
        default: codec_irq_lines_o <= 4'h0;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      codec_dma_route_o <= '0;
      codec_irq_sense_o <= 1'b0;
    end
    else
    begin
      codec_irq_sense_o <= codec_cfg_reg.irq_sense_source;
      unique case (codec_cfg_reg.codec_dma_select)
        3'h0: codec_dma_route_o <= {1'b0, 2'h0, 1'b0, 2'h0};
        3'h1: codec_dma_route_o <= {1'b1, 2'h0, 1'b0, 2'h0};
        3'h2: codec_dma_route_o <= {1'b1, 2'h1, 1'b0, 2'h0};
        3'h3: codec_dma_route_o <= {1'b1, 2'h3, 1'b0, 2'h0};
        3'h4: codec_dma_route_o <= {1'b0, 2'h0, 1'b1, 2'h1};
        3'h5: codec_dma_route_o <= {1'b1, 2'h0, 1'b1, 2'h1};
        3'h6: codec_dma_route_o <= {1'b1, 2'h1, 1'b1, 2'h0};
        3'h7: codec_dma_route_o <= {1'b1, 2'h3, 1'b1, 2'h0};
      endcase
    end
  end

  // Pins set as inputs read the pad; pins set as outputs read back the driven value.
  wire [2:0] pin_read = (general_pin_direction_o & general_pin_value_o)
    | (~general_pin_direction_o & general_pin_i);

  always_comb
  begin
    rdata_next = 8'h00;
    if (hit_index)
      rdata_next = index_reg;
    else if (hit_data)
    begin
      unique case (index_reg)
        `AH_IDX_BUTTON_ROUTE: rdata_next = {3'h0, button_irq_select_reg, 2'h0,
          ext_rom_select_n_reg};
        `AH_IDX_BUTTON_STATUS: rdata_next = {cd_iface_enabled_reg, vol_up_pressed_reg,
          vol_down_pressed_reg, both_buttons_pressed_reg, button_irq_pending_reg,
          auto_config_enabled_reg, 2'h0};
        `AH_IDX_SYNTH_OPTIONS: rdata_next = {3'h0, synth_options_o};
        `AH_IDX_GENERAL_PIN: rdata_next = {2'h0, pin_read[2], general_pin_direction_o[2],
          pin_read[1], general_pin_direction_o[1], pin_read[0],
          general_pin_direction_o[0]};
        default: rdata_next = 8'h00;
      endcase
    end
    else if (hit_legacy && io_addr_i[3:0] == `AH_OFS_READ_DATA)
      rdata_next = out_data_reg;
    else if (hit_legacy && io_addr_i[3:0] == `AH_OFS_COMMAND)
      rdata_next = {input_buffer_full_reg, out_data_reg[6:0]};
    else if (hit_legacy && io_addr_i[3:0] == `AH_OFS_OUT_STATUS)
      rdata_next = {output_buffer_full_reg, out_data_reg[6:0]};
    else if (hit_codec)
      rdata_next = {channel_reduced_reg, codec_irq_active_reg, `AH_VERSION_CODE};
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      io_rdata_o <= 8'h00;
    else if (io_rd_i)
      io_rdata_o <= rdata_next;
    else
      io_rdata_o <= 8'h00;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  button_route_a: assert property (button_irq_pending_reg && button_irq_select_reg == 2'h1
    |=> button_irq_lines_o == 3'b001) else $error("button irq not on first line");
  reserved_read_a: assert property (rd_data && index_reg == `AH_IDX_RESERVED_A
    |=> io_rdata_o == 8'h00) else $error("reserved indirect read not zero");
  status_clear_a: assert property (rd_data && index_reg == `AH_IDX_BUTTON_STATUS
    && !btn_event |=> !button_irq_pending_reg && !vol_up_pressed_reg)
    else $error("button status kept");
  button_set_a: assert property (vol_up_i && vol_down_i
    |=> both_buttons_pressed_reg && button_irq_pending_reg) else $error("button press lost");
  soft_reset_a: assert property (wr_soft_reset && io_wdata_i[0]
    |=> proc_soft_reset_o) else $error("soft reset flag not set");
  input_full_a: assert property (wr_command |=> input_buffer_full_reg
    && proc_in_data_o == $past(io_wdata_i)) else $error("command not latched");
  output_clear_a: assert property (rd_read_data && !proc_out_write_i
    |=> !output_buffer_full_reg) else $error("output full not cleared");
  irq_clear_a: assert property (rd_out_status && !proc_irq_req_i
    |=> !proc_irq_o) else $error("processor irq not cleared");
  codec_irq_a: assert property (codec_cfg_reg.codec_irq_select == 3'h5
    |=> codec_irq_lines_o == 4'h0) else $error("reserved irq code drives a line");
  dma_route_a: assert property (codec_cfg_reg.codec_dma_select == 3'h6 ##1
    codec_cfg_reg.codec_dma_select == 3'h6 |-> codec_dma_route_o == 6'b101100)
    else $error("dma route wrong");
  version_read_a: assert property (io_rd_i && hit_codec && !hit_legacy
    && !hit_index && !hit_data |=> io_rdata_o[5:0] == `AH_VERSION_CODE)
    else $error("version code wrong");

endmodule

`default_nettype wire

/* File: hdl/audio_host_defs.svh */
// Offsets, field positions, reset values and codes of the audio host control registers.
`ifndef AUDIO_HOST_DEFS_SVH
`define AUDIO_HOST_DEFS_SVH

`define AH_MC_INDEX_ADDR 12'hf94
`define AH_MC_DATA_ADDR 12'hf95
`define AH_OFS_READ_DATA 4'ha
`define AH_OFS_SOFT_RESET 4'hb
`define AH_OFS_COMMAND 4'hc
`define AH_OFS_OUT_STATUS 4'he

`define AH_IDX_BUTTON_ROUTE 8'h08
`define AH_IDX_RESERVED_A 8'h09
`define AH_IDX_RESERVED_B 8'h0a
`define AH_IDX_RESERVED_C 8'h0b
`define AH_IDX_BUTTON_STATUS 8'h0c
`define AH_IDX_SYNTH_OPTIONS 8'h0d
`define AH_IDX_GENERAL_PIN 8'h0e

`define AH_BTN_SEL_LSB 3
`define AH_SOFT_RESET_BIT 0
`define AH_FULL_BIT 7

`define AH_INDEX_RESET 8'h00
`define AH_SYNTH_RESET 5'h00
`define AH_PIN_RESET 6'h00
`define AH_CFG_RESET 7'h00

// Low six bits of the version register; the value is arbitrary.
`define AH_VERSION_CODE 6'h15

`define AH_BTN_IRQ_OFF 2'h0
`define AH_BTN_IRQ_5 2'h1
`define AH_BTN_IRQ_10 2'h2
`define AH_BTN_IRQ_11 2'h3

`endif

/* File: hdl/audio_host_pkg.sv */
// Types shared by the audio host control register bank.
package audio_host_pkg;

  typedef struct packed {
    logic synth_test_enable;
    logic bass_boost_enable;
    logic enhanced_mode_enable;
    logic serial_dac_format;
    logic synth_source_select;
  } synth_opts_t;

  typedef struct packed {
    logic irq_sense_source;
    logic [2:0] codec_irq_select;
    logic [2:0] codec_dma_select;
  } codec_cfg_t;

  typedef struct packed {
    logic play_en;
    logic [1:0] play_chan;
    logic cap_en;
    logic [1:0] cap_chan;
  } dma_route_t;

  typedef enum logic [2:0] {
    CODEC_IRQ_OFF,
    CODEC_IRQ_7,
    CODEC_IRQ_9,
    CODEC_IRQ_10,
    CODEC_IRQ_11
  } codec_irq_code_t;

endpackage

/* File: sim/host_bus_model.sv */
// Host I/O bus master model with one-cycle read and write strobes.
`timescale 1ns/100ps
`default_nettype none

module host_bus_model (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output logic [11:0] addr_o,
  output logic rd_o,
  output logic wr_o,
  output logic [7:0] wdata_o
);
  initial
  begin
    addr_o = 12'h000;
    rd_o = 1'b0;
    wr_o = 1'b0;
    wdata_o = 8'h00;
  end

  // Index writes and command bytes both leave the host through this strobe.
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    // Released data is inverted so that a late sample cannot match by chance.
    wdata_o <= ~d;
  endtask

  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    #1 d = rdata_i;
  endtask
endmodule

`default_nettype wire

/* File: sim/audio_host_control_registers_test.sv */
// Self-checking bench for the audio host control register bank.
`timescale 1ns/100ps
`default_nettype none
`include "audio_host_defs.svh"

module audio_host_control_registers_test;
  import audio_host_pkg::*;
  localparam logic [11:0] LB = 12'h220;
  localparam logic [11:0] CB = 12'h530;
  localparam logic [6:0] UP = 7'h40, DN = 7'h20, TAKE = 7'h10, OWR = 7'h08;
  localparam logic [6:0] DMA = 7'h04, IRQ = 7'h02, DONE = 7'h01;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [11:0] io_addr_i;
  logic io_rd_i, io_wr_i, proc_soft_reset_o, proc_irq_o, codec_irq_sense_o;
  logic [7:0] io_wdata_i, io_rdata_o, proc_in_data_o, proc_out_data_i;
  logic [11:0] legacy_audio_base_i = LB;
  logic [11:0] codec_mode_base_i = CB;
  logic proc_in_take_i, proc_out_write_i, dma_out_read_i, proc_irq_req_i, proc_reset_done_i;
  logic vol_up_i, vol_down_i, ext_rom_select_n_i, cd_iface_enabled_i;
  logic auto_config_enabled_i, channel_reduced_i, codec_irq_i;
  logic [2:0] button_irq_lines_o, general_pin_i, general_pin_value_o, general_pin_direction_o;
  logic [3:0] codec_irq_lines_o;
  dma_route_t codec_dma_route_o;
  synth_opts_t synth_options_o;
  logic [6:0] ev = 7'h00;
  logic [5:0] dma_tab [8] = '{6'h00, 6'h20, 6'h28, 6'h38, 6'h05, 6'h25, 6'h2c, 6'h3c};
  logic [7:0] v, q;
  int err_count = 0;
  int n_tests = 0;
  int seed, i;

  assign {vol_up_i, vol_down_i, proc_in_take_i, proc_out_write_i} = ev[6:3];
  assign {dma_out_read_i, proc_irq_req_i, proc_reset_done_i} = ev[2:0];

  always #5 clk_i = ~clk_i;

  host_bus_model host_bus_model_i (.clk_i, .rdata_i(io_rdata_o), .addr_o(io_addr_i),
    .rd_o(io_rd_i), .wr_o(io_wr_i), .wdata_o(io_wdata_i));

  audio_host_control_registers audio_host_control_registers_i (.clk_i, .rst_i, .io_addr_i,
    .io_rd_i, .io_wr_i, .io_wdata_i, .io_rdata_o, .legacy_audio_base_i, .codec_mode_base_i,
    .proc_in_take_i, .proc_in_data_o, .proc_out_write_i, .proc_out_data_i, .dma_out_read_i,
    .proc_irq_req_i, .proc_reset_done_i, .proc_soft_reset_o, .proc_irq_o, .vol_up_i,
    .vol_down_i, .ext_rom_select_n_i, .cd_iface_enabled_i, .auto_config_enabled_i,
    .channel_reduced_i, .codec_irq_i, .button_irq_lines_o, .codec_irq_lines_o,
    .codec_irq_sense_o, .codec_dma_route_o, .synth_options_o, .general_pin_i,
    .general_pin_value_o, .general_pin_direction_o);

  task automatic conclude();
    if (err_count == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e)
    begin
      $display("wrong value at %0t: got %h, expected %h", $time, g, e);
      err_count++;
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic pulse(input logic [6:0] m);
    @(posedge clk_i);
    ev <= m;
    @(posedge clk_i);
    ev <= 7'h00;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] x);
    host_bus_model_i.wr(a, x);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [7:0] e);
    logic [7:0] r;
    host_bus_model_i.rd(a, r);
    chk(r, e);
  endtask

  task automatic iwr(input logic [7:0] x, input logic [7:0] y);
    wr(12'hf94, x);
    wr(12'hf95, y);
  endtask

  task automatic ird(input logic [7:0] x, input logic [7:0] e);
    wr(12'hf94, x);
    rdc(12'hf95, e);
  endtask

  // A pin set as input reads its pad, not the stored value bit.
  function automatic logic [7:0] pins(input logic [7:0] w, input logic [2:0] p);
    pins = 8'h00;
    for (int k = 0; k < 3; k++)
    begin
      pins[2*k] = w[2*k];
      pins[2*k+1] = w[2*k] ? w[2*k+1] : p[k];
    end
  endfunction

  initial
  begin
    #400000;
    $display("wrong value at %0t: watchdog expired", $time);
    err_count++;
    conclude();
  end

  initial
  begin
    seed = 32'h3d38;
    proc_out_data_i = 8'h00;
    codec_irq_i = 1'b0;
    general_pin_i = 3'h0;
    {ext_rom_select_n_i, cd_iface_enabled_i, auto_config_enabled_i} = 3'($random(seed));
    channel_reduced_i = 1'($random(seed));
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(12'hf94, 8'h00);
    ird(8'h0d, 8'h00);
    rdc(12'h300, 8'h00);
    for (i = 0; i < 6; i++)
    begin
      v = (i == 0) ? 8'hff : 8'($random(seed));
      general_pin_i <= 3'($random(seed));
      iwr(8'h0d, v);
      ird(8'h0d, {3'h0, v[4:0]});
      chk({3'h0, synth_options_o}, {3'h0, v[4:0]});
      iwr(8'h0e, v);
      ird(8'h0e, pins(v, general_pin_i));
      chk({2'h0, general_pin_direction_o, general_pin_value_o},
        {2'h0, v[4], v[2], v[0], v[5], v[3], v[1]});
    end
    for (i = 9; i < 12; i++)
    begin
      iwr(8'(i), 8'hff);
      ird(8'(i), 8'h00);
    end
    for (i = 0; i < 4; i++)
    begin
      ext_rom_select_n_i <= i[1];
      {cd_iface_enabled_i, auto_config_enabled_i} <= 2'($random(seed));
      iwr(8'h08, 8'(i << 3));
      ird(8'h08, {3'h0, 2'(i), 2'h0, ext_rom_select_n_i});
      pulse(i[0] ? DN : UP);
      tick(3);
      chk({5'h0, button_irq_lines_o}, (i == 0) ? 8'h00 : 8'h01 << (i - 1));
      ird(8'h0c, {cd_iface_enabled_i, ~i[0], i[0], 2'h1, auto_config_enabled_i, 2'h0});
      ird(8'h0c, {cd_iface_enabled_i, 4'h0, auto_config_enabled_i, 2'h0});
    end
    // Both buttons in one cycle, with the last select still routing to the third line.
    pulse(UP | DN);
    tick(1);
    chk({5'h0, button_irq_lines_o}, 8'h04);
    ird(8'h0c, {cd_iface_enabled_i, 4'hf, auto_config_enabled_i, 2'h0});
    v = 8'($random(seed));
    q = 8'($random(seed));
    wr(LB + 12'h00c, v);
    tick(0);
    chk(proc_in_data_o, v);
    proc_out_data_i <= q;
    pulse(OWR | IRQ);
    rdc(LB + 12'h00c, {1'b1, q[6:0]});
    pulse(TAKE);
    rdc(LB + 12'h00c, {1'b0, q[6:0]});
    chk({7'h0, proc_irq_o}, 8'h01);
    rdc(LB + 12'h00e, {1'b1, q[6:0]});
    chk({7'h0, proc_irq_o}, 8'h00);
    pulse(DMA);
    rdc(LB + 12'h00e, {1'b0, q[6:0]});
    rdc(LB + 12'h00a, q);
    wr(LB + 12'h00b, 8'h01);
    tick(0);
    chk({7'h0, proc_soft_reset_o}, 8'h01);
    pulse(DONE);
    tick(0);
    chk({7'h0, proc_soft_reset_o}, 8'h00);
    wr(LB + 12'h00b, 8'h01);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    tick(0);
    chk({7'h0, proc_soft_reset_o}, 8'h00);
    rdc(12'hf94, 8'h00);
    codec_irq_i <= 1'b1;
    for (i = 0; i < 8; i++)
    begin
      v = {1'b0, i[0], i[2:0], 3'(7 - i)};
      channel_reduced_i <= i[1];
      wr(CB, v);
      tick(3);
      chk({1'b0, codec_irq_sense_o, codec_dma_route_o}, {1'b0, v[6], dma_tab[v[2:0]]});
      chk({4'h0, codec_irq_lines_o}, (i >= 1 && i <= 4) ? 8'h01 << (i - 1) : 8'h00);
      rdc(CB + 12'(i % 4), {channel_reduced_i, 1'b1, `AH_VERSION_CODE});
    end
    codec_irq_i <= 1'b0;
    tick(3);
    rdc(CB + 12'h003, {channel_reduced_i, 1'b0, `AH_VERSION_CODE});
    conclude();
  end
endmodule

`default_nettype wire
